// >>> crs_map.svh
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// System register numbers
`define CRS_SR_EXC_PC 5'h00
`define CRS_SR_EXC_PSW 5'h01
`define CRS_SR_NMI_PC 5'h02
`define CRS_SR_NMI_PSW 5'h03
`define CRS_SR_CAUSE 5'h04
`define CRS_SR_PSW 5'h05
`define CRS_SR_CT_PC 5'h10
`define CRS_SR_CT_PSW 5'h11
`define CRS_SR_DB_PC 5'h12
`define CRS_SR_DB_PSW 5'h13
`define CRS_SR_CT_BASE 5'h14
// Field layout
`define CRS_PC_BITS 26
`define CRS_PSW_BITS 8
`define CRS_PSW_NMI_BIT 7
`define CRS_PSW_EXC_BIT 6
`define CRS_PSW_ID_BIT 5
`define CRS_GPR_EP 5'h1e
// Reset values
`define CRS_PC_RESET 26'h0000000
`define CRS_PSW_RESET 8'h20
`define CRS_ZERO32 32'h00000000
`endif

// >>> crs_pkg.sv
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_EV_NONE, CRS_EV_SWEXC, CRS_EV_MASKINT, CRS_EV_NMI,
    CRS_EV_TBLCALL, CRS_EV_DBGTRAP
  } crs_event_e;
  typedef struct packed {
    logic we;
    logic [4:0] num;
    logic [31:0] data;
  } crs_sysreg_wr_s;
  typedef struct packed {
    logic valid;
    crs_event_e kind;
    logic [25:0] next_pc;
    logic [31:0] code;
  } crs_event_s;
  typedef enum logic [1:0] {
    CRS_RET_NONE, CRS_RET_INT, CRS_RET_NMI, CRS_RET_DBG
  } crs_return_e;
endpackage

// >>> crs_regs.sv
`timescale 1ns/100ps
`include "crs_map.svh"
// Overview of operation
// - General and system registers are 32 bits; separate program counter.
// - General register zero always reads zero; writes are dropped.
// - Short-format loads and stores use register thirty as base.
// - PC keeps 26 bits; upper bits zero, carry out of 25 lost.
// - PC bit zero is held at zero.
// - Five-bit number selects system registers 0-5 and 16-20.
// - Numbers 6-15 and 21-31 are reserved and not accessed.
// - Cause register is read-only; load-system-register writes ignored.
// - Debug save registers reachable only inside a debug-trap window.
// - Bit zero of a saved PC is ignored on return.
// - Exception or maskable interrupt saves next PC and status.
// - NMI saves into NMI save registers, exception saves untouched.
// - Saved PC bits 31-26 and saved status bits 31-8 read zero.
// - Interrupt return restores PC and status from exception saves.
// - Every interrupt or exception writes its code to cause register; a table call leaves the cause register unchanged.
// - Status write by load instruction applies to the next instruction.
// - Interrupt acknowledgement waits while status write is in progress.
// - Pipeline has five stages, single-cycle completion for most.
// - Table call saves next PC and status into table-call saves.
// - Debug trap saves next PC and status into debug save registers.
// - Status bit seven set on NMI acknowledge; a further NMI is still taken.
module crs_regs
  import crs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // General register ports
  input wire logic gpr_we_i,
  input wire logic [4:0] gpr_wnum_i,
  input wire logic [31:0] gpr_wdata_i,
  input wire logic [4:0] gpr_rnum_a_i,
  input wire logic [4:0] gpr_rnum_b_i,
  input wire logic short_mem_i,
  output logic [31:0] gpr_rdata_a_o,
  output logic [31:0] gpr_rdata_b_o,
  // Program counter
  input wire logic pc_we_i,
  input wire logic [31:0] pc_wdata_i,
  output logic [31:0] pc_o,
  // System register access
  input wire crs_sysreg_wr_s sr_wr_i,
  input wire logic [4:0] sr_rnum_i,
  output logic [31:0] sr_rdata_o,
  output logic sr_access_err_o,
  // Events and returns
  input wire crs_event_s event_i,
  input wire crs_return_e return_i,
  input wire logic [7:0] psw_flags_i,
  input wire logic psw_flags_we_i,
  // Status
  output logic [31:0] psw_o,
  output logic int_hold_o,
  output logic nmi_active_flag_o,
  output logic debug_window_o
);

  logic [31:0] gpr [1:31];
  logic [25:0] pc;
  logic [25:0] exc_return_pc, nmi_return_pc, table_call_return_pc;
  logic [25:0] trap_return_pc, table_call_base;
  logic [7:0] exc_return_status, nmi_return_status;
  logic [7:0] table_call_return_status, trap_return_status;
  logic [7:0] program_status_word;
  logic [31:0] cause_code_reg;
  logic dbg_win;
  logic psw_wr_busy;

  // All checks below run on the core clock and pause in reset
  default clocking cb_chk @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Register zero is never stored, so reads of it are constant
  function automatic logic [31:0] gpr_read(input logic [4:0] n);
    gpr_read = (n == 5'h00) ? `CRS_ZERO32 : gpr[n];
  endfunction

  function automatic logic sr_legal(input logic [4:0] n, input logic dw);
    case (n)
      `CRS_SR_EXC_PC, `CRS_SR_EXC_PSW, `CRS_SR_NMI_PC, `CRS_SR_NMI_PSW,
      `CRS_SR_CAUSE, `CRS_SR_PSW, `CRS_SR_CT_PC, `CRS_SR_CT_PSW,
      `CRS_SR_CT_BASE: sr_legal = 1'b1;
      `CRS_SR_DB_PC, `CRS_SR_DB_PSW: sr_legal = dw;
      default: sr_legal = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] pc_ext(input logic [25:0] v);
    pc_ext = {6'h00, v};
  endfunction

  function automatic logic [31:0] psw_ext(input logic [7:0] v);
    psw_ext = {24'h000000, v};
  endfunction

  // Decoded write strobes
  wire wr_ok = sr_wr_i.we && sr_legal(sr_wr_i.num, dbg_win);
  wire wr_epc = wr_ok && sr_wr_i.num == `CRS_SR_EXC_PC;
  wire wr_epsw = wr_ok && sr_wr_i.num == `CRS_SR_EXC_PSW;
  wire wr_npc = wr_ok && sr_wr_i.num == `CRS_SR_NMI_PC;
  wire wr_npsw = wr_ok && sr_wr_i.num == `CRS_SR_NMI_PSW;
  wire wr_psw = wr_ok && sr_wr_i.num == `CRS_SR_PSW;
  wire wr_cpc = wr_ok && sr_wr_i.num == `CRS_SR_CT_PC;
  wire wr_cpsw = wr_ok && sr_wr_i.num == `CRS_SR_CT_PSW;
  wire wr_dpc = wr_ok && sr_wr_i.num == `CRS_SR_DB_PC;
  wire wr_dpsw = wr_ok && sr_wr_i.num == `CRS_SR_DB_PSW;
  wire wr_ctb = wr_ok && sr_wr_i.num == `CRS_SR_CT_BASE;
  wire [25:0] wr_pc26 = sr_wr_i.data[25:0];
  wire [7:0] wr_psw8 = sr_wr_i.data[7:0];

  // Event decode; an event is not taken while a status write is in flight
  wire ev_take = event_i.valid && !psw_wr_busy;
  wire ev_exc = ev_take && (event_i.kind == CRS_EV_SWEXC ||
                            event_i.kind == CRS_EV_MASKINT);
  wire ev_nmi = ev_take && event_i.kind == CRS_EV_NMI;
  wire ev_ct = ev_take && event_i.kind == CRS_EV_TBLCALL;
  wire ev_db = ev_take && event_i.kind == CRS_EV_DBGTRAP;
  wire ev_cause = ev_exc || ev_nmi || ev_db;
  wire [25:0] ev_pc = {event_i.next_pc[25:1], 1'b0};

  // Next PC; the 26-bit width drops any carry out of bit 25
  logic [25:0] next_pc;
  always_comb begin
    next_pc = pc;
    if (pc_we_i) begin
      next_pc = {pc_wdata_i[25:1], 1'b0};
    end
    case (return_i)
      CRS_RET_INT: next_pc = {exc_return_pc[25:1], 1'b0};
      CRS_RET_NMI: next_pc = {nmi_return_pc[25:1], 1'b0};
      CRS_RET_DBG: next_pc = {trap_return_pc[25:1], 1'b0};
      default: ;
    endcase
  end

  // Next status word; later assignments take priority
  logic [7:0] next_psw;
  always_comb begin
    next_psw = program_status_word;
    if (psw_flags_we_i) begin
      next_psw = psw_flags_i;
    end
    if (wr_psw) begin
      next_psw = wr_psw8;
    end
    case (return_i)
      CRS_RET_INT: next_psw = exc_return_status;
      CRS_RET_NMI: next_psw = nmi_return_status;
      CRS_RET_DBG: next_psw = trap_return_status;
      default: ;
    endcase
    if (ev_exc) begin
      next_psw[`CRS_PSW_EXC_BIT] = 1'b1;
      next_psw[`CRS_PSW_ID_BIT] = 1'b1;
    end
    if (ev_nmi) begin
      next_psw[`CRS_PSW_NMI_BIT] = 1'b1;
      next_psw[`CRS_PSW_ID_BIT] = 1'b1;
    end
  end

  // General registers; index 0 is absent from the array
  genvar gi;
  generate
    for (gi = 1; gi < 32; gi++) begin : g_gpr
      always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
          gpr[gi] <= `CRS_ZERO32;
        end else if (gpr_we_i && gpr_wnum_i == 5'(gi)) begin
          gpr[gi] <= gpr_wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      pc <= `CRS_PC_RESET;
      program_status_word <= `CRS_PSW_RESET;
    end else begin
      pc <= next_pc;
      program_status_word <= next_psw;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      exc_return_pc <= `CRS_PC_RESET;
      exc_return_status <= 8'h00;
    end else if (ev_exc) begin
      exc_return_pc <= ev_pc;
      exc_return_status <= program_status_word;
    end else if (wr_epc || wr_epsw) begin
      if (wr_epc) exc_return_pc <= wr_pc26;
      if (wr_epsw) exc_return_status <= wr_psw8;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      nmi_return_pc <= `CRS_PC_RESET;
      nmi_return_status <= 8'h00;
    end else if (ev_nmi) begin
      nmi_return_pc <= ev_pc;
      nmi_return_status <= program_status_word;
    end else if (wr_npc || wr_npsw) begin
      if (wr_npc) nmi_return_pc <= wr_pc26;
      if (wr_npsw) nmi_return_status <= wr_psw8;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      table_call_return_pc <= `CRS_PC_RESET;
      table_call_return_status <= 8'h00;
    end else if (ev_ct) begin
      table_call_return_pc <= ev_pc;
      table_call_return_status <= program_status_word;
    end else if (wr_cpc || wr_cpsw) begin
      if (wr_cpc) table_call_return_pc <= wr_pc26;
      if (wr_cpsw) table_call_return_status <= wr_psw8;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      trap_return_pc <= `CRS_PC_RESET;
      trap_return_status <= 8'h00;
    end else if (ev_db) begin
      trap_return_pc <= ev_pc;
      trap_return_status <= program_status_word;
    end else if (wr_dpc || wr_dpsw) begin
      if (wr_dpc) trap_return_pc <= wr_pc26;
      if (wr_dpsw) trap_return_status <= wr_psw8;
    end
  end

  // Table base keeps bit 0 at zero like the PC
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      table_call_base <= `CRS_PC_RESET;
    end else if (wr_ctb) begin
      table_call_base <= {wr_pc26[25:1], 1'b0};
    end
  end

  // Cause register has no write path from software
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cause_code_reg <= `CRS_ZERO32;
    end else if (ev_cause) begin
      cause_code_reg <= event_i.code;
    end
  end

  // Debug window opens on a trap and closes on the debug return
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      dbg_win <= 1'b0;
    end else if (ev_db) begin
      dbg_win <= 1'b1;
    end else if (return_i == CRS_RET_DBG) begin
      dbg_win <= 1'b0;
    end
  end

  // One-cycle hold covers the write landing in the status word
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      psw_wr_busy <= 1'b0;
    end else begin
      psw_wr_busy <= wr_psw;
    end
  end

  // System register read mux
  logic [31:0] sr_mux;
  always_comb begin
    case (sr_rnum_i)
      `CRS_SR_EXC_PC: sr_mux = pc_ext(exc_return_pc);
      `CRS_SR_EXC_PSW: sr_mux = psw_ext(exc_return_status);
      `CRS_SR_NMI_PC: sr_mux = pc_ext(nmi_return_pc);
      `CRS_SR_NMI_PSW: sr_mux = psw_ext(nmi_return_status);
      `CRS_SR_CAUSE: sr_mux = cause_code_reg;
      `CRS_SR_PSW: sr_mux = psw_ext(program_status_word);
      `CRS_SR_CT_PC: sr_mux = pc_ext(table_call_return_pc);
      `CRS_SR_CT_PSW: sr_mux = psw_ext(table_call_return_status);
      `CRS_SR_DB_PC: sr_mux = dbg_win ? pc_ext(trap_return_pc) : `CRS_ZERO32;
      `CRS_SR_DB_PSW:
        sr_mux = dbg_win ? psw_ext(trap_return_status) : `CRS_ZERO32;
      `CRS_SR_CT_BASE: sr_mux = pc_ext(table_call_base);
      default: sr_mux = `CRS_ZERO32;
    endcase
  end

  // Short loads and stores take register thirty as the base on port A
  wire [4:0] rnum_a = short_mem_i ? `CRS_GPR_EP : gpr_rnum_a_i;
  wire rd_err = !sr_legal(sr_rnum_i, dbg_win);
  wire wr_err = sr_wr_i.we && (!sr_legal(sr_wr_i.num, dbg_win) ||
                               sr_wr_i.num == `CRS_SR_CAUSE);

  // Data outputs registered; pipeline stages live outside this block
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      gpr_rdata_a_o <= `CRS_ZERO32;
      gpr_rdata_b_o <= `CRS_ZERO32;
      sr_rdata_o <= `CRS_ZERO32;
      sr_access_err_o <= 1'b0;
    end else begin
      gpr_rdata_a_o <= gpr_read(rnum_a);
      gpr_rdata_b_o <= gpr_read(gpr_rnum_b_i);
      sr_rdata_o <= sr_mux;
      sr_access_err_o <= rd_err || wr_err;
    end
  end

  assign pc_o = pc_ext(pc);
  assign psw_o = psw_ext(program_status_word);
  assign nmi_active_flag_o = program_status_word[`CRS_PSW_NMI_BIT];
  assign int_hold_o = psw_wr_busy || wr_psw;
  assign debug_window_o = dbg_win;

  a_pc_even_bits: assert property (
    pc_o[0] == 1'b0 && pc_o[31:26] == 6'h00)
    else $error("PC odd or upper bits set");
  a_zero_reg: assert property (
    !short_mem_i && gpr_rnum_a_i == 5'h00 |=> gpr_rdata_a_o == 32'h0)
    else $error("register zero not zero");
  a_exc_save_pc: assert property (
    ev_exc |=> exc_return_pc == $past(ev_pc))
    else $error("exception save PC wrong");
  a_nmi_keeps_exc: assert property (
    ev_nmi && !wr_epc |=> $stable(exc_return_pc) && nmi_active_flag_o)
    else $error("NMI disturbed exception saves");
  a_cause_ro: assert property (
    !ev_cause |=> $stable(cause_code_reg))
    else $error("cause register changed without event");
  a_int_return: assert property (
    return_i == CRS_RET_INT |=>
      pc == {$past(exc_return_pc[25:1]), 1'b0})
    else $error("return did not restore PC");
  sequence s_psw_load;
    wr_psw ##1 1'b1;
  endsequence
  a_int_hold_psw: assert property (
    s_psw_load |-> int_hold_o)
    else $error("interrupt not held after status write");
  a_dbg_gate: assert property (
    !dbg_win && !ev_db |=> $stable(trap_return_pc) || $past(ev_db))
    else $error("debug save written outside window");
  a_reserved_zero: assert property (
    sr_rnum_i inside {[5'h06:5'h0f], [5'h15:5'h1f]} |=>
      sr_rdata_o == 32'h0 && sr_access_err_o)
    else $error("reserved number gave data");
endmodule // crs_regs

// >>> crs_regs_tb_top.sv
`timescale 1ns/100ps
module crs_regs_tb_top
  import crs_pkg::*;
();
  logic ref_clk_i, rst_b_i, gpr_we_i, short_mem_i, pc_we_i, psw_flags_we_i;
  logic [4:0] gpr_wnum_i, gpr_rnum_a_i, gpr_rnum_b_i, sr_rnum_i;
  logic [31:0] gpr_wdata_i, pc_wdata_i;
  logic [7:0] psw_flags_i;
  crs_sysreg_wr_s sr_wr_i;
  crs_event_s event_i;
  crs_return_e return_i;
  logic [31:0] gpr_rdata_a_o, gpr_rdata_b_o, pc_o, sr_rdata_o, psw_o;
  logic sr_access_err_o, int_hold_o, nmi_active_flag_o, debug_window_o;
  int n_mismatch, n_checks, cyc;
  logic [4:0] rw_n [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h14};
  logic [31:0] rw_x [7] = '{32'h03ffffff, 32'h000000ff, 32'h03ffffff,
    32'h000000ff, 32'h03ffffff, 32'h000000ff, 32'h03fffffe};
  logic [4:0] rs_n [4] = '{5'h06, 5'h0f, 5'h15, 5'h1f};

  crs_regs uut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .gpr_we_i(gpr_we_i), .gpr_wnum_i(gpr_wnum_i), .gpr_wdata_i(gpr_wdata_i),
    .gpr_rnum_a_i(gpr_rnum_a_i), .gpr_rnum_b_i(gpr_rnum_b_i),
    .short_mem_i(short_mem_i), .gpr_rdata_a_o(gpr_rdata_a_o),
    .gpr_rdata_b_o(gpr_rdata_b_o), .pc_we_i(pc_we_i),
    .pc_wdata_i(pc_wdata_i), .pc_o(pc_o), .sr_wr_i(sr_wr_i),
    .sr_rnum_i(sr_rnum_i), .sr_rdata_o(sr_rdata_o),
    .sr_access_err_o(sr_access_err_o), .event_i(event_i),
    .return_i(return_i), .psw_flags_i(psw_flags_i),
    .psw_flags_we_i(psw_flags_we_i), .psw_o(psw_o),
    .int_hold_o(int_hold_o), .nmi_active_flag_o(nmi_active_flag_o),
    .debug_window_o(debug_window_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Budget is over twenty times the expected length of the sequence
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      $display("BAD t=%0t run did not finish", $time);
      summarize();
    end
  end

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Read number is parked on a legal place so the error flag shows the write
  task sw(input logic [4:0] n, input logic [31:0] d, input logic e);
    @(posedge ref_clk_i);
    sr_wr_i <= '{1'b1, n, d};
    sr_rnum_i <= 5'h05;
    @(posedge ref_clk_i);
    sr_wr_i <= '0;
    #1 chk1(sr_access_err_o, e);
  endtask

  task sr(input logic [4:0] n, input logic [31:0] x, input logic e,
          input logic cd);
    @(posedge ref_clk_i);
    sr_rnum_i <= n;
    @(posedge ref_clk_i);
    #1 chk1(sr_access_err_o, e);
    if (cd) chk32(sr_rdata_o, x);
  endtask

  task ev(input crs_event_e k, input logic [25:0] p, input logic [31:0] c);
    @(posedge ref_clk_i);
    event_i <= '{1'b1, k, p, c};
    @(posedge ref_clk_i);
    event_i <= '0;
    #1;
  endtask

  task rt(input crs_return_e k);
    @(posedge ref_clk_i);
    return_i <= k;
    @(posedge ref_clk_i);
    return_i <= CRS_RET_NONE;
    #1;
  endtask

  task gw(input logic [4:0] n, input logic [31:0] d);
    @(posedge ref_clk_i);
    gpr_we_i <= 1'b1;
    gpr_wnum_i <= n;
    gpr_wdata_i <= d;
    @(posedge ref_clk_i);
    gpr_we_i <= 1'b0;
  endtask

  task gr(input logic [4:0] a, input logic [4:0] b, input logic s,
          input logic [31:0] xa, input logic [31:0] xb);
    @(posedge ref_clk_i);
    gpr_rnum_a_i <= a;
    gpr_rnum_b_i <= b;
    short_mem_i <= s;
    @(posedge ref_clk_i);
    #1 chk32(gpr_rdata_a_o, xa);
    chk32(gpr_rdata_b_o, xb);
  endtask

  initial begin
    {rst_b_i, gpr_we_i, short_mem_i, pc_we_i, psw_flags_we_i} = '0;
    {gpr_wnum_i, gpr_rnum_a_i, gpr_rnum_b_i, sr_rnum_i} = '0;
    {gpr_wdata_i, pc_wdata_i, psw_flags_i} = '0;
    sr_wr_i = '0;
    event_i = '0;
    return_i = CRS_RET_NONE;
    {n_mismatch, n_checks, cyc} = '0;
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    #1 chk32(pc_o, 32'h0);
    chk32(psw_o, 32'h20);
    chk1(debug_window_o, 1'b0);
    sr(5'h00, 32'h0, 1'b0, 1'b1);
    $display("test reset done");
    gw(5'h00, 32'hffffffff);
    gw(5'h05, 32'h12345678);
    gw(5'h1e, 32'h0000abcd);
    gr(5'h00, 5'h05, 1'b0, 32'h0, 32'h12345678);
    gr(5'h05, 5'h00, 1'b1, 32'h0000abcd, 32'h0);
    @(posedge ref_clk_i);
    pc_we_i <= 1'b1;
    pc_wdata_i <= 32'hffffffff;
    @(posedge ref_clk_i);
    pc_we_i <= 1'b0;
    #1 chk32(pc_o, 32'h03fffffe);
    $display("test general and pc done");
    for (int i = 0; i < 7; i++) sw(rw_n[i], 32'hffffffff, 1'b0);
    for (int i = 0; i < 7; i++) sr(rw_n[i], rw_x[i], 1'b0, 1'b1);
    sw(5'h04, 32'hffffffff, 1'b1);
    sr(5'h04, 32'h0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) sw(rs_n[i], 32'hffffffff, 1'b1);
    for (int i = 0; i < 4; i++) sr(rs_n[i], 32'h0, 1'b1, 1'b1);
    sw(5'h12, 32'h00000100, 1'b1);
    sr(5'h12, 32'h0, 1'b1, 1'b1);
    $display("test system access done");
    // Event lands in the hold cycle and must be dropped
    @(posedge ref_clk_i);
    sr_wr_i <= '{1'b1, 5'h05, 32'hffffff25};
    #1 chk1(int_hold_o, 1'b1);
    @(posedge ref_clk_i);
    sr_wr_i <= '0;
    event_i <= '{1'b1, CRS_EV_MASKINT, 26'h0000100, 32'h10};
    #1 chk32(psw_o, 32'h25);
    chk1(int_hold_o, 1'b1);
    @(posedge ref_clk_i);
    event_i <= '0;
    #1 chk1(int_hold_o, 1'b0);
    sr(5'h00, 32'h03ffffff, 1'b0, 1'b1);
    $display("test status hold done");
    ev(CRS_EV_MASKINT, 26'h2345678, 32'h11);
    chk32(psw_o, 32'h65);
    sr(5'h00, 32'h02345678, 1'b0, 1'b1);
    sr(5'h01, 32'h25, 1'b0, 1'b1);
    sr(5'h04, 32'h11, 1'b0, 1'b1);
    ev(CRS_EV_NMI, 26'h0000aaa, 32'h20);
    chk32(psw_o, 32'he5);
    chk1(nmi_active_flag_o, 1'b1);
    sr(5'h02, 32'h00000aaa, 1'b0, 1'b1);
    sr(5'h03, 32'h65, 1'b0, 1'b1);
    sr(5'h00, 32'h02345678, 1'b0, 1'b1);
    sr(5'h04, 32'h20, 1'b0, 1'b1);
    sw(5'h05, 32'h20, 1'b0);
    ev(CRS_EV_DBGTRAP, 26'h0000ccc, 32'h60);
    chk1(debug_window_o, 1'b1);
    sr(5'h12, 32'h00000ccc, 1'b0, 1'b1);
    sr(5'h13, 32'h20, 1'b0, 1'b1);
    sr(5'h04, 32'h60, 1'b0, 1'b1);
    rt(CRS_RET_DBG);
    chk1(debug_window_o, 1'b0);
    chk32(pc_o, 32'h00000ccc);
    chk32(psw_o, 32'h20);
    sr(5'h12, 32'h0, 1'b1, 1'b1);
    sw(5'h05, 32'h20, 1'b0);
    ev(CRS_EV_TBLCALL, 26'h0000bbc, 32'h99);
    sr(5'h10, 32'h00000bbc, 1'b0, 1'b1);
    sr(5'h11, 32'h20, 1'b0, 1'b1);
    sr(5'h04, 32'h60, 1'b0, 1'b1);
    $display("test events done");
    sw(5'h00, 32'h00001235, 1'b0);
    sw(5'h01, 32'hffffff03, 1'b0);
    rt(CRS_RET_INT);
    chk32(pc_o, 32'h00001234);
    chk32(psw_o, 32'h03);
    rt(CRS_RET_NMI);
    chk32(pc_o, 32'h00000aaa);
    chk32(psw_o, 32'h65);
    chk1(nmi_active_flag_o, 1'b0);
    // Status write beats a flag update in the same cycle
    @(posedge ref_clk_i);
    psw_flags_we_i <= 1'b1;
    psw_flags_i <= 8'h0f;
    sr_wr_i <= '{1'b1, 5'h05, 32'h000000a0};
    @(posedge ref_clk_i);
    psw_flags_we_i <= 1'b0;
    sr_wr_i <= '0;
    #1 chk32(psw_o, 32'ha0);
    @(posedge ref_clk_i);
    psw_flags_we_i <= 1'b1;
    @(posedge ref_clk_i);
    psw_flags_we_i <= 1'b0;
    #1 chk32(psw_o, 32'h0f);
    $display("test returns done");
    summarize();
  end
endmodule // crs_regs_tb_top
